// ===== motor_status_defs.svh
// register offsets, field positions, reset values and frame layout of the status bank
`ifndef MOTOR_STATUS_DEFS_SVH
`define MOTOR_STATUS_DEFS_SVH

// status word offsets on the serial link
`define FAULT_MAIN_ADDR   5'h05
`define COIL_X_ADDR       5'h06
`define COIL_Y_ADDR       5'h07
`define IDENTITY_ADDR     5'h08
`define BACKEMF_ADDR      5'h09
`define SPEED_ADDR        5'h0A

// status word fields
`define WORD_MSB_POS      9
`define PARITY_POS        8
`define DEFECT_SUM_POS    5
`define SPI_ERR_POS       6

// serial frame layout
`define FRAME_WR_POS      15
`define FRAME_ADDR_HI     14
`define FRAME_ADDR_LO     10
`define FRAME_PARITY_LO   8
`define FRAME_MOD_BITS    4

// latch reset values; the hard reset latch comes out of reset set
`define MAIN_LAT_RST      5'h08
`define COIL_X_LAT_RST    7'h00
`define COIL_Y_LAT_RST    5'h00
`define BACKEMF_LAT_RST   1'h0
`define TX_WORD_RST       16'h0000

`endif

// ===== motor_status_pkg.sv
// types and helpers shared by the status register bank
package motor_status_pkg;

    typedef logic [9:0]  status_word_t;
    typedef logic [15:0] spi_frame_t;
    typedef logic [4:0]  reg_addr_t;

    // bit 9 always zero, bit 8 makes the nine low bits odd
    function automatic status_word_t make_word(input logic [7:0] flags);
        return {1'b0, ~(^flags), flags};
    endfunction : make_word

endpackage : motor_status_pkg

// ===== flag_latch_bank.sv
// bank of sticky status flags, cleared on read, with set winning over clear
`timescale 1ns/1ns
module flag_latch_bank #(
    parameter int               WIDTH   = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    // clock, reset, enable
    input  wire logic             ref_clk,
    input  wire logic             rst_n,
    input  wire logic             ce,
    // events and read clear
    input  wire logic [WIDTH-1:0] set,
    input  wire logic             clear_on_read,
    // sticky flags
    output logic [WIDTH-1:0]      flags_q
);

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            flags_q <= RST_VAL;
        end else if (ce) begin
            flags_q <= (clear_on_read ? '0 : flags_q) | set;
        end
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    chk_set_beats_clear: assert property (
        ce && clear_on_read |=> (flags_q & $past(set)) == $past(set)
    ) else $error("event lost in a clear-on-read cycle");

    chk_clear_empties: assert property (
        ce && clear_on_read && set == '0 |=> flags_q == '0
    ) else $error("read did not clear latched flags");

    cov_set_and_clear: cover property (ce && clear_on_read && set != '0);

endmodule : flag_latch_bank

// ===== motor_driver_status_regs.sv
// read-only status bank of the stepper driver, read over the serial link
//
// Function
// - status words are read-only, writes ignored, bit 9 always reads zero
// - bit 8 is odd parity over itself and the eight flags below
// - latched flags stay set until their word is read, then clear
// - real-time flags show the live condition; reading them changes nothing
// - defect summary bit 5 is the OR of all short and open latches
// - reading the defect summary clears neither it nor its latches
// - serial error latches when a frame has not a multiple of 16 edges
// - identity word holds 5-bit part id in 7:3, revision in 2:0
// - back-EMF coil bit reads 0 for coil X, 1 for coil Y
// - back-EMF polarity bit reads 0 when polarity was as expected
// - 5-bit back-EMF magnitude sits in bits 4:0 of its word
// - result-ready latch in bit 7 sets when a new back-EMF value arrives
// - third word shows live step pin in bit 6, direction pin bit 5
// - hard reset latch reads 1 after the device went through reset
// - live low-temperature flag sits in bit 4 of the first word
// - undervoltage latch bit 1; bridge brakes or opens per action select
// - eight short latches, per pin to ground and supply, bits 3:0
// - open coil latches for X and Y in bit 4 of words two and three
// - sixth word shows live 8-bit speed value in bits 7:0
// - stall latch bit 0 of first word sets on a detected stall
// - flags without fixed reset value take reset-phase diagnostic results
// - serial error clears only on parity-correct read; error pin releases once thermal shutdown, undervoltage and all short and open latches are clear too
`timescale 1ns/1ns
`include "motor_status_defs.svh"
module motor_driver_status_regs
    import motor_status_pkg::*;
#(
    parameter logic [4:0] PART_ID    = 5'h0A, // arbitrary value
    parameter logic [2:0] REVISION   = 3'h1,  // arbitrary value
    parameter int         EDGE_CNT_W = 8
) (
    // clock, reset, enable
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    input  wire logic       ce,
    // serial link
    input  wire logic       serial_clk,
    input  wire logic       chip_select_line_n,
    input  wire logic       serial_data_in,
    output logic            serial_data_out,
    // open-drain error pin, pulled low while oe is high
    output logic            error_output_pin_o,
    output logic            error_output_pin_oe,
    // live pins
    input  wire logic       step_pulse_input,
    input  wire logic       direction_input,
    // fault events from the sensing logic
    input  wire logic       step_loss_evt,
    input  wire logic       stall_evt,
    input  wire logic       undervoltage_evt,
    input  wire logic       undervoltage_warning_evt,
    input  wire logic       thermal_shutdown_evt,
    input  wire logic       coil_x_open_evt,
    input  wire logic       coil_y_open_evt,
    input  wire logic [3:0] coil_x_short_evt,
    input  wire logic [3:0] coil_y_short_evt,
    input  wire logic       backemf_ready_evt,
    // real-time conditions
    input  wire logic       low_temp_flag,
    input  wire logic       thermal_warning_flag,
    input  wire logic       backemf_coil_indicator,
    input  wire logic       backemf_polarity,
    input  wire logic [4:0] backemf_value,
    input  wire logic [7:0] speed_value,
    // undervoltage bridge response
    input  wire logic       undervoltage_action_select,
    output logic            bridge_brake_q,
    output logic            bridge_open_q
);

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    // ---------------- link domain ----------------
    // the counter runs free; frames are told apart by its value at each frame end,
    // so the link side needs no edge outside a frame and no reset per frame
    logic [EDGE_CNT_W-1:0] edge_cnt_q;
    spi_frame_t            shift_q;
    logic [EDGE_CNT_W-1:0] cnt_base_q;
    spi_frame_t            tx_q;
    logic [3:0]            bit_pos;

    always_ff @(posedge serial_clk or negedge rst_n) begin
        if (!rst_n) begin
            edge_cnt_q <= '0;
        end else begin
            edge_cnt_q <= edge_cnt_q + 1'b1;
        end
    end

    always_ff @(posedge serial_clk or negedge rst_n) begin
        if (!rst_n) begin
            shift_q <= `TX_WORD_RST;
        end else begin
            shift_q <= {shift_q[14:0], serial_data_in};
        end
    end

    // position in frame; cnt_base_q and tx_q hold still while the frame runs
    assign bit_pos = edge_cnt_q[3:0] - cnt_base_q[3:0];

    always_ff @(negedge serial_clk or negedge rst_n) begin
        if (!rst_n) begin
            serial_data_out <= 1'b0;
        end else begin
            serial_data_out <= tx_q[~bit_pos];
        end
    end

    // ---------------- pin synchronisers ----------------
    logic cs_s1_q, cs_s2_q, cs_s3_q;
    logic step_s1_q, step_s2_q;
    logic dir_s1_q, dir_s2_q;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cs_s1_q <= 1'b1;
            cs_s2_q <= 1'b1;
            cs_s3_q <= 1'b1;
        end else if (ce) begin
            cs_s1_q <= chip_select_line_n;
            cs_s2_q <= cs_s1_q;
            cs_s3_q <= cs_s2_q;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            step_s1_q <= 1'b0;
            step_s2_q <= 1'b0;
            dir_s1_q  <= 1'b0;
            dir_s2_q  <= 1'b0;
        end else if (ce) begin
            step_s1_q <= step_pulse_input;
            step_s2_q <= step_s1_q;
            dir_s1_q  <= direction_input;
            dir_s2_q  <= dir_s1_q;
        end
    end

    // ---------------- frame decode ----------------
    logic                  frame_end;
    logic [EDGE_CNT_W-1:0] edge_diff;
    logic                  frame_any;
    logic                  frame_bad;
    logic                  rd_req;
    reg_addr_t             rd_addr;

    // link registers are sampled only after the synchronised frame end,
    // when the link clock has stopped and they are stable
    assign frame_end = ce && cs_s2_q && !cs_s3_q;
    assign edge_diff = edge_cnt_q - cnt_base_q;
    assign frame_any = edge_diff != '0;
    assign frame_bad = frame_end && frame_any
                       && edge_diff[`FRAME_MOD_BITS-1:0] != '0;
    assign rd_addr   = shift_q[`FRAME_ADDR_HI:`FRAME_ADDR_LO];
    // writes never reach a status word; a read needs odd parity over 15:8
    assign rd_req    = frame_end && frame_any && !frame_bad
                       && !shift_q[`FRAME_WR_POS]
                       && ^shift_q[`FRAME_WR_POS:`FRAME_PARITY_LO];

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_base_q <= '0;
        end else if (frame_end) begin
            cnt_base_q <= edge_cnt_q;
        end
    end

    // ---------------- latched flags ----------------
    // latches other than the hard reset latch reset to zero and then catch the diagnostic results that the
    // sensing logic presents on its event inputs right after the release
    logic [4:0] main_lat_q;  // step loss, hard reset, undervoltage warning, undervoltage, stall
    logic [6:0] x_lat_q;     // serial error, thermal shutdown, open X, shorts X
    logic [4:0] y_lat_q;     // open Y, shorts Y
    logic       bemf_lat_q;
    logic [4:0] main_set;
    logic [6:0] x_set;
    logic [4:0] y_set;

    assign main_set = {step_loss_evt, 1'b0, undervoltage_warning_evt, undervoltage_evt, stall_evt};
    assign x_set    = {frame_bad, thermal_shutdown_evt, coil_x_open_evt, coil_x_short_evt};
    assign y_set    = {coil_y_open_evt, coil_y_short_evt};

    flag_latch_bank #(.WIDTH(5), .RST_VAL(`MAIN_LAT_RST)) main_bank (
        .ref_clk       (ref_clk),
        .rst_n         (rst_n),
        .ce            (ce),
        .set           (main_set),
        .clear_on_read (rd_req && rd_addr == `FAULT_MAIN_ADDR),
        .flags_q       (main_lat_q)
    );

    flag_latch_bank #(.WIDTH(7), .RST_VAL(`COIL_X_LAT_RST)) coil_x_bank (
        .ref_clk       (ref_clk),
        .rst_n         (rst_n),
        .ce            (ce),
        .set           (x_set),
        .clear_on_read (rd_req && rd_addr == `COIL_X_ADDR),
        .flags_q       (x_lat_q)
    );

    flag_latch_bank #(.WIDTH(5), .RST_VAL(`COIL_Y_LAT_RST)) coil_y_bank (
        .ref_clk       (ref_clk),
        .rst_n         (rst_n),
        .ce            (ce),
        .set           (y_set),
        .clear_on_read (rd_req && rd_addr == `COIL_Y_ADDR),
        .flags_q       (y_lat_q)
    );

    flag_latch_bank #(.WIDTH(1), .RST_VAL(`BACKEMF_LAT_RST)) bemf_bank (
        .ref_clk       (ref_clk),
        .rst_n         (rst_n),
        .ce            (ce),
        .set           (backemf_ready_evt),
        .clear_on_read (rd_req && rd_addr == `BACKEMF_ADDR),
        .flags_q       (bemf_lat_q)
    );

    // ---------------- word assembly ----------------
    logic         electrical_defect_summary;
    status_word_t rd_word;

    // summary reads the latches; it is no latch itself and drops only once reads of words two and three clear them
    assign electrical_defect_summary = |x_lat_q[4:0] || |y_lat_q;

    always_comb begin
        case (rd_addr)
            `FAULT_MAIN_ADDR: rd_word = make_word({main_lat_q[4:3], electrical_defect_summary, low_temp_flag,
                                                   main_lat_q[2], thermal_warning_flag,
                                                   main_lat_q[1:0]});
            `COIL_X_ADDR:     rd_word = make_word({1'b0, x_lat_q});
            `COIL_Y_ADDR:     rd_word = make_word({1'b0, step_s2_q, dir_s2_q, y_lat_q});
            `IDENTITY_ADDR:   rd_word = make_word({PART_ID, REVISION});
            `BACKEMF_ADDR:    rd_word = make_word({bemf_lat_q, backemf_coil_indicator,
                                                   backemf_polarity, backemf_value});
            `SPEED_ADDR:      rd_word = make_word(speed_value);
            default:          rd_word = '0;
        endcase
    end

    // the answer goes out in the next frame; anything but a good read answers zero
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_q <= `TX_WORD_RST;
        end else if (frame_end && frame_any) begin
            tx_q <= rd_req ? {6'h00, rd_word} : `TX_WORD_RST;
        end
    end

    // ---------------- error pin and bridge ----------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            error_output_pin_o  <= 1'b0;
            error_output_pin_oe <= 1'b0;
        end else if (ce) begin
            error_output_pin_o  <= 1'b0;
            error_output_pin_oe <= x_lat_q[6] || x_lat_q[5] || electrical_defect_summary || main_lat_q[1];
        end
    end

    // the bridge holds its response while undervoltage is seen or still latched
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            bridge_brake_q <= 1'b0;
            bridge_open_q  <= 1'b0;
        end else if (ce) begin
            bridge_brake_q <= (undervoltage_evt || main_lat_q[1]) && undervoltage_action_select;
            bridge_open_q  <= (undervoltage_evt || main_lat_q[1]) && !undervoltage_action_select;
        end
    end

    // ---------------- checks ----------------
    logic        any_set;
    logic [17:0] lat_all;

    assign any_set = |main_set || |x_set || |y_set || backemf_ready_evt;
    assign lat_all = {main_lat_q, x_lat_q, y_lat_q, bemf_lat_q};

    chk_word_msb_zero: assert property (
        tx_q[15:`WORD_MSB_POS] == '0
    ) else $error("status answer has a non-zero top bit");

    chk_word_parity: assert property (
        tx_q != '0 |-> ^tx_q[`PARITY_POS:0]
    ) else $error("status answer parity is not odd");

    chk_live_read_quiet: assert property (
        rd_req && rd_addr == `SPEED_ADDR && !any_set |=> $stable(lat_all)
    ) else $error("reading live speed changed stored flags");

    chk_defect_summary: assert property (
        rd_req && rd_addr == `FAULT_MAIN_ADDR
        |=> tx_q[`DEFECT_SUM_POS] == $past(|x_lat_q[4:0] || |y_lat_q)
    ) else $error("defect summary does not follow the latches");

    chk_defect_keeps: assert property (
        rd_req && rd_addr == `FAULT_MAIN_ADDR && !any_set
        |=> $stable({x_lat_q[4:0], y_lat_q})
            && electrical_defect_summary == $past(electrical_defect_summary)
    ) else $error("summary read cleared the short or open latches");

    chk_spi_err_latch: assert property (
        frame_bad |=> x_lat_q[`SPI_ERR_POS] && tx_q == '0
    ) else $error("bad edge count did not latch the serial error");

    chk_identity_word: assert property (
        rd_req && rd_addr == `IDENTITY_ADDR |=> tx_q[7:0] == {PART_ID, REVISION}
    ) else $error("identity word wrong");

    chk_bemf_fields: assert property (
        rd_req && rd_addr == `BACKEMF_ADDR
        |=> tx_q[6:0] == $past({backemf_coil_indicator, backemf_polarity, backemf_value})
    ) else $error("back-EMF fields wrong");

    chk_bemf_ready: assert property (
        ce && backemf_ready_evt |=> bemf_lat_q [*1] ##1 (bemf_lat_q || $past(rd_req))
    ) else $error("result ready not latched");

    chk_pin_levels: assert property (
        rd_req && rd_addr == `COIL_Y_ADDR |=> tx_q[6:5] == $past({step_s2_q, dir_s2_q})
    ) else $error("pin levels wrong in third word");

    chk_undervolt_response: assert property (
        ce && main_lat_q[1] |=> bridge_brake_q == $past(undervoltage_action_select)
                                && bridge_open_q == !$past(undervoltage_action_select)
    ) else $error("undervoltage bridge response wrong");

    chk_err_pin_set: assert property (
        frame_bad ##1 ce |=> error_output_pin_oe
    ) else $error("serial error did not pull the error pin");

    cov_good_read:   cover property (rd_req);
    cov_bad_frame:   cover property (frame_bad);
    cov_err_cleared: cover property (rd_req && rd_addr == `COIL_X_ADDR && x_lat_q[`SPI_ERR_POS]);

endmodule : motor_driver_status_regs

// ===== spi_master_model.sv
// host side of the serial link: frames status reads and captures the answer
`timescale 1ns/1ns
module spi_master_model (
    // serial link driven by the host
    output logic        serial_clk,
    output logic        chip_select_line_n,
    output logic        serial_data_in,
    // answer from the device
    input  wire logic   serial_data_out,
    output logic [15:0] rx_q,
    output logic        rx_done
);
    initial begin
        serial_clk         = 1'b0;
        chip_select_line_n = 1'b1;
        serial_data_in     = 1'b0;
        rx_q               = 16'h0000;
        rx_done            = 1'b0;
    end

    // header bits 15:8 carry an odd count of ones; badp spoils it on purpose
    function automatic logic [15:0] hdr(input logic wr, input logic [4:0] a, input logic badp);
        return {wr, a, 1'b0, ~^{wr, a} ^ badp, 8'h00};
    endfunction : hdr

    // clock runs only inside a frame; lead stretches the select-to-first-edge gap
    task automatic xfer(input logic [15:0] f, input int edges, input int lead);
        logic [15:0] sh;
        logic [15:0] rx;
        // keep the select edge off the device clock edge
        #13;
        sh                 = f;
        rx                 = 16'h0000;
        chip_select_line_n = 1'b0;
        serial_data_in     = sh[15];
        #(40 + lead);
        for (int i = 0; i < edges; i++) begin
            serial_clk     = 1'b1;
            rx             = {rx[14:0], serial_data_out};
            sh             = {sh[14:0], 1'b0};
            #40;
            serial_clk     = 1'b0;
            serial_data_in = sh[15];
            #40;
        end
        // released line shows the inverse so a stale bit cannot pass as data
        serial_data_in     = ~serial_data_in;
        chip_select_line_n = 1'b1;
        rx_q               = rx;
        rx_done            = ~rx_done;
    endtask : xfer
endmodule : spi_master_model

// ===== tb.sv
// self-checking bench for the status register bank
`timescale 1ns/1ns
module tb;
    import motor_status_pkg::*;

    localparam logic [4:0] PART_ID  = 5'h0C; // arbitrary value
    localparam logic [2:0] REVISION = 3'h5;  // arbitrary value

    logic        ref_clk, rst_n, ce, serial_clk, chip_select_line_n, serial_data_in, serial_data_out;
    logic        error_output_pin_o, error_output_pin_oe, bridge_brake_q, bridge_open_q;
    logic        step_pulse_input, direction_input, low_temp_flag, thermal_warning_flag;
    logic        backemf_coil_indicator, backemf_polarity, undervoltage_action_select;
    logic [4:0]  backemf_value;
    logic [7:0]  speed_value;
    logic [15:0] ev, lat, rx_q;
    logic        rx_done, hard_rst_lat, spi_err;
    spi_frame_t  pending;
    spi_frame_t  expq[$];
    reg_addr_t   seq[5] = '{5'h05, 5'h05, 5'h06, 5'h07, 5'h09};
    int          num_errors, check_count;

    motor_driver_status_regs #(.PART_ID(PART_ID), .REVISION(REVISION)) motor_driver_status_regs_i (
        .ref_clk(ref_clk), .rst_n(rst_n), .ce(ce), .serial_clk(serial_clk),
        .chip_select_line_n(chip_select_line_n), .serial_data_in(serial_data_in),
        .serial_data_out(serial_data_out), .error_output_pin_o(error_output_pin_o),
        .error_output_pin_oe(error_output_pin_oe), .step_pulse_input(step_pulse_input),
        .direction_input(direction_input), .step_loss_evt(ev[0]), .stall_evt(ev[1]),
        .undervoltage_evt(ev[2]), .undervoltage_warning_evt(ev[3]), .thermal_shutdown_evt(ev[4]),
        .coil_x_open_evt(ev[5]), .coil_y_open_evt(ev[6]),
        .coil_x_short_evt(ev[10:7]), .coil_y_short_evt(ev[14:11]), .backemf_ready_evt(ev[15]),
        .low_temp_flag(low_temp_flag), .thermal_warning_flag(thermal_warning_flag),
        .backemf_coil_indicator(backemf_coil_indicator), .backemf_polarity(backemf_polarity),
        .backemf_value(backemf_value), .speed_value(speed_value),
        .undervoltage_action_select(undervoltage_action_select),
        .bridge_brake_q(bridge_brake_q), .bridge_open_q(bridge_open_q));

    spi_master_model spi_master_model_i (
        .serial_clk(serial_clk), .chip_select_line_n(chip_select_line_n), .serial_data_in(serial_data_in),
        .serial_data_out(serial_data_out), .rx_q(rx_q), .rx_done(rx_done));

    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    function automatic logic [7:0] flags_of(input reg_addr_t a);
        case (a)
            5'h05: return {lat[0], hard_rst_lat, |lat[14:5], low_temp_flag, lat[3], thermal_warning_flag,
                           lat[2], lat[1]};
            5'h06: return {1'b0, spi_err, lat[4], lat[5], lat[10:7]};
            5'h07: return {1'b0, step_pulse_input, direction_input, lat[6], lat[14:11]};
            5'h08: return {PART_ID, REVISION};
            5'h09: return {lat[15], backemf_coil_indicator, backemf_polarity, backemf_value};
            5'h0A: return speed_value;
            default: return 8'h00;
        endcase
    endfunction : flags_of

    // latches that a good read of each word leaves standing
    function automatic logic [15:0] keep_mask(input reg_addr_t a);
        case (a)
            5'h05: return 16'hFFF0;
            5'h06: return 16'hF84F;
            5'h07: return 16'h87BF;
            5'h09: return 16'h7FFF;
            default: return 16'hFFFF;
        endcase
    endfunction : keep_mask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // the answer of a frame shows up one frame later, so the note is for the frame after
    task automatic send(input reg_addr_t a, input logic wr, input logic badp, input int edges);
        logic good;
        good = !wr && !badp && edges == 16 && a >= 5'h05 && a <= 5'h0A;
        expq.push_back(pending >> (16 - edges));
        pending = good ? {7'h00, ~^flags_of(a), flags_of(a)} : 16'h0000;
        if (good) begin
            lat          = lat & keep_mask(a);
            hard_rst_lat = hard_rst_lat && a != 5'h05;
            spi_err      = spi_err && a != 5'h06;
        end
        if (edges != 16) spi_err = 1'b1;
        spi_master_model_i.xfer(spi_master_model_i.hdr(wr, a, badp), edges, $urandom_range(300, 0));
        repeat (8) @(posedge ref_clk);
    endtask : send

    task automatic pins;
        repeat (3) @(posedge ref_clk);
        check(16'(error_output_pin_oe), 16'(spi_err | lat[4] | (|lat[14:5]) | lat[2]));
        check(16'(error_output_pin_o), 16'h0000);
        check(16'({bridge_brake_q, bridge_open_q}),
              16'({lat[2] & undervoltage_action_select, lat[2] & ~undervoltage_action_select}));
    endtask : pins

    task automatic fire(input logic [15:0] v);
        @(posedge ref_clk);
        ev                         <= v;
        undervoltage_action_select <= 1'($urandom);
        @(posedge ref_clk);
        ev                         <= 16'h0000;
        lat                         = lat | v;
        pins();
    endtask : fire

    task automatic live;
        @(posedge ref_clk);
        {step_pulse_input, direction_input, low_temp_flag, thermal_warning_flag} <= 4'($urandom);
        {backemf_coil_indicator, backemf_polarity, backemf_value}               <= 7'($urandom);
        speed_value                                                              <= 8'($urandom);
        repeat (4) @(posedge ref_clk);
    endtask : live

    task automatic summarize;
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : summarize

    // each finished frame is compared with the oldest note
    initial begin
        @(posedge rst_n);
        forever begin
            @(rx_done);
            check(rx_q, expq.pop_front());
        end
    end

    initial begin
        #3_000_000;
        num_errors++;
        summarize();
    end

    initial begin
        void'($urandom(32'h74db_0d54));
        {rst_n, ev, lat, pending, num_errors, check_count} = '0;
        {step_pulse_input, direction_input, low_temp_flag, thermal_warning_flag} = '0;
        {backemf_coil_indicator, backemf_polarity, backemf_value, speed_value}   = '0;
        undervoltage_action_select = 1'b0;
        ce                         = 1'b1;
        hard_rst_lat               = 1'b1;
        spi_err                    = 1'b0;
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        send(5'h05, 1'b0, 1'b0, 16);
        send(5'h05, 1'b0, 1'b0, 16);
        $display("test reset_flags done");
        for (int i = 0; i < 4; i++) begin
            live();
            for (int a = 5; a <= 10; a++) send(5'(a), 1'b0, 1'b0, 16);
        end
        $display("test live_words done");
        for (int i = 0; i < 16; i++) begin
            fire(16'h0001 << i);
            foreach (seq[k]) send(seq[k], 1'b0, 1'b0, 16);
            pins();
        end
        $display("test latches done");
        fire(16'hFFFF);
        send(5'h05, 1'b1, 1'b0, 16);
        send(5'h05, 1'b0, 1'b1, 16);
        send(5'h0B, 1'b0, 1'b0, 16);
        send(5'h06, 1'b0, 1'b0, 15);
        pins();
        foreach (seq[k]) send(seq[k], 1'b0, 1'b0, 16);
        pins();
        // an undervoltage event while the enable is low must leave no trace
        @(posedge ref_clk);
        {ce, ev} <= {1'b0, 16'h0004};
        repeat (3) @(posedge ref_clk);
        {ce, ev} <= {1'b1, 16'h0000};
        pins();
        send(5'h0A, 1'b0, 1'b0, 16);
        $display("test refusals done");
        summarize();
    end
endmodule : tb
